// ### hw/crs_pkg.sv
// Purpose: shared constants and types of the conversion readback sequencer
// Assumes: one serial word of 32 bits per chip-select low period
// Notes:   crc polynomial is a parameter of plain default
package crs_pkg;
  localparam int          FRAME_BITS     = 32;
  localparam int          CRC_BITS       = 12;
  localparam logic [4:0]  ADDR_BCAST     = 5'h1f;
  localparam logic [5:0]  REG_CONV_CTRL  = 6'h3d;
  localparam logic [5:0]  REG_PAGE_SEL   = 6'h3e;
  localparam logic [5:0]  REG_READ_SEL   = 6'h3f;
  localparam logic [7:0]  CONV_START     = 8'h01;
  localparam logic [7:0]  CONV_SECONDARY = 8'h02;
  localparam logic [7:0]  CONV_EXIT      = 8'h04;
  localparam logic [7:0]  CONV_CTRL_RST  = 8'h00;
  localparam logic [7:0]  PAGE_SEL_RST   = 8'h00;
  localparam logic [7:0]  READ_SEL_RST   = 8'hff;
  localparam logic [4:0]  DEV_ID_RST     = 5'h00;
  localparam int          PRIMARY_CNT    = 18;
  localparam int          SECONDARY_CNT  = 10;
  localparam logic [11:0] CRC_POLY       = 12'h80f;
  localparam logic [11:0] CRC_INIT       = 12'h000;

  typedef struct packed {
    logic [4:0]  dev_addr;
    logic        wr;
    logic [5:0]  reg_addr;
    logic [7:0]  data;
    logic [11:0] crc;
  } crs_cmd_s;

  typedef enum logic [2:0] {
    CRS_CMD32 = 3'b001,
    CRS_PRIM  = 3'b010,
    CRS_SEC   = 3'b100
  } crs_mode_e;
endpackage

// ### hw/crs_sequencer.sv
// Purpose: serial command decode and conversion readback of one device
// Assumes: sclk/cs/mosi sampled synchronously to sys_clk; chain link is
//          word-wide: downstream words arrive on chain_in_* for relaying
// Notes:   results come from the converter as a flat array input
module crs_sequencer (
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     mosi,
  output logic                          miso,
  input  wire logic [crs_pkg::PRIMARY_CNT*16-1:0]   prim_results,
  input  wire logic [crs_pkg::SECONDARY_CNT*16-1:0] sec_results,
  input  wire logic                     conv_done,
  input  wire logic                     chain_in_valid,
  input  wire logic [31:0]              chain_in_word,
  output logic                          conv_start,
  output logic [7:0]                    page_sel,
  output logic [1:0]                    read_mode,
  output logic                          crc_error
);
  import crs_pkg::*;

  logic [31:0]     shift_in_ff;
  logic [31:0]     shift_out_ff;
  logic [5:0]      bit_cnt_ff;
  logic            sclk_d_ff;
  logic            cs_d_ff;
  logic [7:0]      conv_ctrl_ff;
  logic [7:0]      page_sel_ff;
  logic [7:0]      read_sel_ff;
  logic [7:0]      reg_rd_val;
  crs_mode_e       mode_ff;
  logic [4:0]      res_idx_ff;
  logic            conv_busy_ff;
  logic            conv_start_ff;
  logic            crc_err_ff;
  logic            fetched_ff;
  logic [31:0]     chain_word_ff;
  logic            chain_have_ff;
  logic [11:0]     crc_calc;
  logic            frame_end;
  logic            rise;
  logic            fall;
  logic [31:0]     word;
  crs_cmd_s        cmd;
  logic            for_us;
  logic [31:0]     own_word;
  logic [15:0]     res_val;

  assign rise = sclk && !sclk_d_ff && !cs_n;
  assign fall = !sclk && sclk_d_ff && !cs_n;
  // a frame counts only if exactly 32 clocks were framed
  assign frame_end = cs_n && !cs_d_ff && (bit_cnt_ff == 6'(FRAME_BITS));
  assign word = shift_in_ff;
  assign cmd  = crs_cmd_s'(word);
  assign for_us = (cmd.dev_addr == ADDR_BCAST) || (cmd.dev_addr == DEV_ID_RST);

  // serial crc over the leading address, flag, register and data bits
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_calc = CRC_INIT;
    for (int i = 31; i >= CRC_BITS; i--) begin
      fb = word[i] ^ crc_calc[CRC_BITS-1];
      crc_calc = {crc_calc[CRC_BITS-2:0], 1'b0};
      if (fb) begin
        crc_calc = crc_calc ^ CRC_POLY;
      end
    end
  end

  // null words carry zero crc and are never acted upon
  logic cmd_ok;
  assign cmd_ok = frame_end && cmd.wr && for_us && (crc_calc == cmd.crc);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk;
      cs_d_ff   <= cs_n;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_in_ff <= '0;
      bit_cnt_ff  <= '0;
    end else if (cs_n && !cs_d_ff) begin
      bit_cnt_ff <= '0;
    end else if (rise) begin
      shift_in_ff <= {shift_in_ff[30:0], mosi};
      if (bit_cnt_ff != 6'h3f) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_err_ff <= 1'b0;
    end else if (frame_end) begin
      crc_err_ff <= (word != '0) && (crc_calc != cmd.crc);
    end
  end

  // register writes; page select is reachable on either page
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_ctrl_ff <= CONV_CTRL_RST;
      page_sel_ff  <= PAGE_SEL_RST;
      read_sel_ff  <= READ_SEL_RST;
    end else if (cmd_ok) begin
      case (cmd.reg_addr)
        REG_CONV_CTRL: conv_ctrl_ff <= cmd.data;
        REG_PAGE_SEL:  page_sel_ff  <= cmd.data;
        REG_READ_SEL:  read_sel_ff  <= cmd.data;
        default: ;
      endcase
    end
  end

  // upper two bits of the read register are ignored; unknown addresses read 0
  always_comb begin
    reg_rd_val = '0;
    case (read_sel_ff[5:0])
      REG_CONV_CTRL: reg_rd_val = conv_ctrl_ff;
      REG_PAGE_SEL:  reg_rd_val = page_sel_ff;
      REG_READ_SEL:  reg_rd_val = read_sel_ff;
      default:       reg_rd_val = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= cmd_ok && (cmd.reg_addr == REG_CONV_CTRL)
                       && cmd.data[0] && (mode_ff == CRS_CMD32);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_busy_ff <= 1'b0;
    end else if (conv_start_ff) begin
      conv_busy_ff <= 1'b1;
    end else if (conv_done) begin
      conv_busy_ff <= 1'b0;
    end
  end

  // mode and result pointer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff    <= CRS_CMD32;
      res_idx_ff <= '0;
    end else begin
      case (mode_ff)
        CRS_CMD32: begin
          if (conv_start_ff) begin
            mode_ff    <= CRS_PRIM;
            res_idx_ff <= '0;
          end
        end
        CRS_PRIM, CRS_SEC: begin
          if (cmd_ok && cmd.reg_addr == REG_CONV_CTRL
              && cmd.data == CONV_EXIT) begin
            mode_ff <= CRS_CMD32;
          end else if (cmd_ok && cmd.reg_addr == REG_CONV_CTRL
                       && cmd.data == CONV_SECONDARY) begin
            mode_ff    <= CRS_SEC;
            res_idx_ff <= '0;
          end else if (fetched_ff && frame_end) begin
            res_idx_ff <= res_idx_ff + 5'h01;
          end
        end
        default: mode_ff <= CRS_CMD32;
      endcase
    end
  end

  // own results go first once the conversion is done; before that, and once they are exhausted, relay words from above
  always_comb begin
    res_val = '0;
    if (mode_ff == CRS_PRIM && res_idx_ff < 5'(PRIMARY_CNT)) begin
      res_val = prim_results[res_idx_ff*16 +: 16];
    end else if (mode_ff == CRS_SEC && res_idx_ff < 5'(SECONDARY_CNT)) begin
      res_val = sec_results[res_idx_ff*16 +: 16];
    end
  end
  assign own_word = {DEV_ID_RST, 3'b000, res_idx_ff, 3'b000, res_val};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_word_ff <= '0;
      chain_have_ff <= 1'b0;
    end else if (chain_in_valid) begin
      chain_word_ff <= chain_in_word;
      chain_have_ff <= 1'b1;
    end else if (cs_d_ff && !cs_n) begin
      chain_have_ff <= 1'b0;
    end
  end

  // load on chip-select fall; once the conversion is done, master data precedes every slave's
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_out_ff <= '0;
      fetched_ff   <= 1'b0;
    end else if (cs_d_ff && !cs_n) begin
      if (mode_ff == CRS_CMD32) begin
        shift_out_ff <= {DEV_ID_RST, 19'h0, reg_rd_val};
        fetched_ff   <= 1'b0;
      // a frame read while converting shifts the held chain word, or zeros if none, and keeps the pointer
      end else if (!conv_busy_ff
                   && ((mode_ff == CRS_PRIM && res_idx_ff < 5'(PRIMARY_CNT))
                   || (mode_ff == CRS_SEC
                       && res_idx_ff < 5'(SECONDARY_CNT)))) begin
        shift_out_ff <= own_word;
        fetched_ff   <= 1'b1;
      end else begin
        shift_out_ff <= chain_have_ff ? chain_word_ff : '0;
        fetched_ff   <= 1'b0;
      end
    end else if (fall) begin
      shift_out_ff <= {shift_out_ff[30:0], 1'b0};
    end
  end

  assign miso       = shift_out_ff[31];
  assign conv_start = conv_start_ff;
  assign page_sel   = page_sel_ff;
  assign read_mode  = {mode_ff == CRS_SEC, mode_ff != CRS_CMD32};
  assign crc_error  = crc_err_ff;
endmodule

// ### dv/crs_sequencer_properties.sv
// Purpose: port assertions of the readback sequencer
// Assumes: one host word per chip-select low period
// Notes:   a shadow shifter rebuilds the last host word
module crs_sequencer_properties (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic       conv_start,
  input wire logic [7:0] page_sel,
  input wire logic [1:0] read_mode,
  input wire logic       crc_error
);
  import crs_pkg::*;

  logic        sclk_q_ff;
  logic        cs_q_ff;
  logic [31:0] sh_ff;
  logic [5:0]  cnt_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
      sh_ff     <= 32'h0;
      cnt_ff    <= 6'h0;
    end else begin
      sclk_q_ff <= sclk;
      cs_q_ff   <= cs_n;
      if (sclk && !sclk_q_ff) begin
        sh_ff  <= {sh_ff[30:0], mosi};
        cnt_ff <= cnt_ff + 6'h1;
      end else if (cs_n && cs_q_ff) begin
        cnt_ff <= 6'h0;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_go; conv_start |-> sh_ff[12] && !read_mode[0]; endproperty
  a_go: assert property (p_go) else $error("stray start");
  property p_enter; conv_start |=> read_mode == 2'b01; endproperty
  a_enter: assert property (p_enter) else $error("no read mode");
  property p_page;
    !$stable(page_sel) |-> page_sel == sh_ff[19:12];
  endproperty
  a_page: assert property (p_page) else $error("page source");
  property p_short;
    $rose(cs_n) && cnt_ff != 6'd32 |=> $stable(page_sel) [*6];
  endproperty
  a_short: assert property (p_short) else $error("short frame used");
  property p_exit; $fell(read_mode[0]) |-> sh_ff[19:12] == CONV_EXIT;
  endproperty
  a_exit: assert property (p_exit) else $error("stray exit");
  property p_sec; $rose(read_mode[1]) |-> sh_ff[19:12] == CONV_SECONDARY;
  endproperty
  a_sec: assert property (p_sec) else $error("stray source");
  property p_miso; sclk && $past(sclk) |-> $stable(miso); endproperty
  a_miso: assert property (p_miso) else $error("miso moved");
  c_start: cover property (conv_start);
  c_sec: cover property (read_mode == 2'b11);
  c_crc: cover property ($rose(crc_error));
endmodule
bind crs_sequencer crs_sequencer_properties u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
  .mosi(mosi), .miso(miso), .conv_start(conv_start),
  .page_sel(page_sel), .read_mode(read_mode), .crc_error(crc_error));

// ### dv/crs_host_model.sv
// Purpose: host side of the serial command port
// Assumes: four system clocks per serial clock phase
// Notes:   sclk rests low between frames
module crs_host_model (
  input  wire logic sys_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // nbits other than 32 gives a frame the device must drop
  task automatic xfer(input logic [31:0] w, input int nbits,
                      output logic [31:0] rd);
    rd = 32'h0;
    @(posedge sys_clk) cs_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      mosi <= w[31-i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd = {rd[30:0], miso};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    // released line: show the inverse so a stale bit is never trusted
    mosi <= ~mosi;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ### dv/test_conversion_readback_sequencer.sv
// Purpose: self-checking bench of the readback sequencer
// Assumes: one device in the chain
// Notes:   crc rebuilt here from the package polynomial
module test_conversion_readback_sequencer
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        sys_clk = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        conv_done = 1'b0;
  logic                        sclk, cs_n, mosi, miso, conv_start, crc_error;
  logic [PRIMARY_CNT*16-1:0]   prim;
  logic [SECONDARY_CNT*16-1:0] sec;
  logic [7:0]                  page_sel;
  logic [1:0]                  read_mode;
  logic [31:0]                 rd;
  logic                        chain_valid = 1'b0;
  logic [31:0]                 chain_word = 32'h0;
  int                          fails = 0;
  int                          tests_run = 0;
  int                          starts = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_start === 1'b1) starts <= starts + 1;
  crs_host_model host (.sys_clk(sys_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));
  crs_sequencer DUT (.sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .prim_results(prim),
    .sec_results(sec), .conv_done(conv_done), .chain_in_valid(chain_valid),
    .chain_in_word(chain_word), .conv_start(conv_start), .page_sel(page_sel),
    .read_mode(read_mode), .crc_error(crc_error));
  function automatic logic [31:0] cmd(logic [5:0] r, logic [7:0] d);
    logic [19:0] h;
    logic [11:0] c;
    h = {ADDR_BCAST, 1'b1, r, d};
    c = CRC_INIT;
    for (int i = 19; i >= 0; i--)
      c = {c[10:0], 1'b0} ^ ((c[11] ^ h[i]) ? CRC_POLY : 12'h0);
    return {h, c};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic read_run(input int n, input logic [31:0] last, input bit s);
    logic [31:0] want;
    for (int k = 0; k < n; k++) begin
      host.xfer(k == n - 1 ? last : 32'h0, 32, rd);
      want = {DEV_ID_RST, 3'h0, 5'(k), 3'h0,
              s ? sec[16*k+:16] : prim[16*k+:16]};
      check(rd, want);
    end
  endtask
  task automatic convert;
    host.xfer(cmd(REG_CONV_CTRL, CONV_START), 32, rd);
    check(read_mode, 2'b01);
    @(posedge sys_clk) conv_done <= 1'b1;
    @(posedge sys_clk) conv_done <= 1'b0;
  endtask
  initial begin
    for (int k = 0; k < PRIMARY_CNT; k++) prim[16*k+:16] = 16'ha500 + 16'(k);
    for (int k = 0; k < SECONDARY_CNT; k++) sec[16*k+:16] = 16'h3c80 + 16'(k);
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({crc_error, read_mode, page_sel}, {3'h0, PAGE_SEL_RST});
    host.xfer(cmd(REG_PAGE_SEL, 8'h03), 32, rd);
    check(page_sel, 8'h03);
    host.xfer(cmd(REG_READ_SEL, {2'b00, REG_PAGE_SEL}), 32, rd);
    host.xfer(32'h0, 32, rd);
    check(rd, {DEV_ID_RST, 19'h0, 8'h03});
    host.xfer(cmd(REG_PAGE_SEL, 8'h00), 31, rd);
    check(page_sel, 8'h03);
    host.xfer(cmd(REG_PAGE_SEL, 8'h00) ^ 32'h1, 32, rd);
    check({crc_error, page_sel}, 9'h103);
    host.xfer(cmd(REG_PAGE_SEL, 8'h00), 32, rd);
    check({crc_error, page_sel}, 9'h000);
    convert();
    check(starts, 1);
    read_run(PRIMARY_CNT, cmd(REG_CONV_CTRL, CONV_SECONDARY), 1'b0);
    check(read_mode, 2'b11);
    read_run(SECONDARY_CNT, cmd(REG_CONV_CTRL, CONV_EXIT), 1'b1);
    check(read_mode, 2'b00);
    convert();
    read_run(PRIMARY_CNT, 32'h0, 1'b0);
    @(posedge sys_clk) chain_valid <= 1'b1;
    chain_word <= 32'h2a5c_0e17;
    @(posedge sys_clk) chain_valid <= 1'b0;
    host.xfer(cmd(REG_CONV_CTRL, CONV_EXIT), 32, rd);
    check(rd, 32'h2a5c_0e17);
    check({starts[1:0], read_mode}, 4'b1000);
    finish_test();
  end
endmodule
